/* pkg/bor_defines.svh */
`ifndef BOR_DEFINES_SVH
`define BOR_DEFINES_SVH

// register byte offsets
`define BOR_ADDR_CTRL 8'h00
`define BOR_ADDR_HOLD 8'h04
`define BOR_ADDR_OFFD 8'h08
`define BOR_ADDR_STAT 8'h0c
`define BOR_ADDR_HOLD_LEFT 8'h10
`define BOR_ADDR_OFFD_LEFT 8'h14

// control register fields
`define BOR_CTRL_INV_LSB 0
`define BOR_CTRL_INV_MSB 6
`define BOR_CTRL_OUTINV 8
`define BOR_CTRL_LATCH 9

// status register fields
`define BOR_STAT_ON 0
`define BOR_STAT_LATCHED 1
`define BOR_STAT_REQ 2
`define BOR_STAT_HOLDING 3
`define BOR_STAT_OFFDLY 4
`define BOR_STAT_RELAY 5
`define BOR_STAT_SIG_LSB 8
`define BOR_STAT_SIG_MSB 14

// reset values
`define BOR_INV_RST 7'h00
`define BOR_BIT_RST 1'h0
`define BOR_TIME_RST 15'h0000

// times: settings count in units of 10 ms, 0.00 s to 300.00 s
`define BOR_TIME_MAX 15'h7530
`define BOR_TICK_NS 10000000
`define BOR_CLK_NS 100
`define BOR_TICK_CYCLES (`BOR_TICK_NS / `BOR_CLK_NS)

`endif

/* pkg/bor_pkg.sv */
package bor_pkg;

  typedef logic [7:0] bor_addr_t;
  typedef logic [31:0] bor_word_t;
  typedef logic [14:0] bor_time_t;
  typedef logic [6:0] bor_sig_t;

  // on-off path of the relay state, gray except the two-bit off-delay to off step
  typedef enum logic [1:0]
  {
    BOR_ST_OFF = 2'h0,
    BOR_ST_ON = 2'h1,
    BOR_ST_OFFDLY = 2'h3
  } bor_state_e;

  typedef struct packed
  {
    bor_sig_t in_inv;
    logic out_inv;
    logic latch_en;
    bor_time_t hold;
    bor_time_t offd;
  } bor_cfg_s;

  typedef struct packed
  {
    logic st_on;
    logic latched;
    logic req;
    logic holding;
    logic offdly;
    logic relay;
  } bor_stat_s;

endpackage

/* src/bor_cond.sv */
`timescale 1ns/1ps
`default_nettype none

module bor_cond
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // assigned signals and their inversion
  input wire bor_pkg::bor_sig_t sig_in,
  input wire bor_pkg::bor_sig_t in_inv,
  // pickup request
  output logic req_r
);
  import bor_pkg::*;

  logic req_nxt;

  always_comb
  begin
    req_nxt = |(sig_in ^ in_inv);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      req_r <= 1'b0;
    else
      req_r <= req_nxt;
  end

endmodule
`default_nettype wire

/* src/bor_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bor_defines.svh"

module bor_timer
#(
  parameter int TICK_CYCLES = `BOR_TICK_CYCLES
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic start,
  input wire bor_pkg::bor_time_t load,
  // state
  output bor_pkg::bor_time_t cnt_r,
  output logic done
);
  import bor_pkg::*;

  logic [16:0] pre_r;
  logic tick;

  // prescaler restarts with each start so a full 10 ms step is always counted
  assign tick = (pre_r == 17'(TICK_CYCLES - 1));
  assign done = (cnt_r == 15'h0000);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pre_r <= 17'h00000;
    else if (start || tick || done)
      pre_r <= 17'h00000;
    else
      pre_r <= pre_r + 17'h00001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_r <= 15'h0000;
    else if (start)
      cnt_r <= load;
    else if (tick && !done)
      cnt_r <= cnt_r - 15'h0001;
  end

endmodule
`default_nettype wire

/* src/bor_top.sv */
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "bor_defines.svh"

module bor_top
#(
  parameter int TICK_CYCLES = `BOR_TICK_CYCLES
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire bor_pkg::bor_addr_t paddr,
  input wire bor_pkg::bor_word_t pwdata,
  output bor_pkg::bor_word_t prdata,
  output logic pready,
  output logic pslverr,
  // assigned signals and acknowledge
  input wire bor_pkg::bor_sig_t sig_in,
  input wire logic ack_in,
  // relay drive
  output logic relay_out
);
  import bor_pkg::*;

  bor_cfg_s cfg_r;
  bor_stat_s stat;
  bor_state_e st_r;
  bor_state_e st_nxt;
  bor_word_t prdata_r;
  bor_word_t rd_word;
  bor_time_t hold_left;
  bor_time_t offd_left;
  logic pready_r;
  logic pslverr_r;
  logic relay_r;
  logic relay_nxt;
  logic latch_r;
  logic latch_nxt;
  logic req;
  logic demand;
  logic hold_start;
  logic hold_done;
  logic off_start;
  logic off_done;
  logic setup;
  logic access;
  logic wr_en;

  // valid register addresses
  function automatic logic addr_ok(input bor_addr_t a);
    begin
      addr_ok = (a == `BOR_ADDR_CTRL) || (a == `BOR_ADDR_HOLD) || (a == `BOR_ADDR_OFFD) ||
                (a == `BOR_ADDR_STAT) || (a == `BOR_ADDR_HOLD_LEFT) || (a == `BOR_ADDR_OFFD_LEFT);
    end
  endfunction

  // settings above 300.00 s are stored as 300.00 s
  function automatic bor_time_t clamp_time(input bor_word_t w);
    begin
      if (w > {17'h00000, `BOR_TIME_MAX})
        clamp_time = `BOR_TIME_MAX;
      else
        clamp_time = w[14:0];
    end
  endfunction

  // input conditioning and pickup request
  bor_cond u_cond
  (
    .pclk(pclk),
    .presetn(presetn),
    .sig_in(sig_in),
    .in_inv(cfg_r.in_inv),
    .req_r(req)
  );

  // minimum hold time after each switch from off to on and from off delay to off
  bor_timer #(.TICK_CYCLES(TICK_CYCLES)) u_hold
  (
    .pclk(pclk),
    .presetn(presetn),
    .start(hold_start),
    .load(cfg_r.hold),
    .cnt_r(hold_left),
    .done(hold_done)
  );

  // switch-off delay
  bor_timer #(.TICK_CYCLES(TICK_CYCLES)) u_offd
  (
    .pclk(pclk),
    .presetn(presetn),
    .start(off_start),
    .load(cfg_r.offd),
    .cnt_r(offd_left),
    .done(off_done)
  );

  // apb phases
  assign setup = psel && !penable;
  assign access = psel && penable && pready_r;
  assign wr_en = access && pwrite && addr_ok(paddr);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready_r <= 1'b0;
    else
      pready_r <= setup;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr_r <= 1'b0;
    else if (setup)
      pslverr_r <= !addr_ok(paddr);
    else
      pslverr_r <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_r <= 32'h00000000;
    else if (setup)
      prdata_r <= pwrite ? 32'h00000000 : rd_word;
  end

  // settings registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_r.in_inv <= `BOR_INV_RST;
      cfg_r.out_inv <= `BOR_BIT_RST;
      cfg_r.latch_en <= `BOR_BIT_RST;
    end
    else if (wr_en && (paddr == `BOR_ADDR_CTRL))
    begin
      cfg_r.in_inv <= pwdata[`BOR_CTRL_INV_MSB:`BOR_CTRL_INV_LSB];
      cfg_r.out_inv <= pwdata[`BOR_CTRL_OUTINV];
      cfg_r.latch_en <= pwdata[`BOR_CTRL_LATCH];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg_r.hold <= `BOR_TIME_RST;
    else if (wr_en && (paddr == `BOR_ADDR_HOLD))
      cfg_r.hold <= clamp_time(pwdata);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg_r.offd <= `BOR_TIME_RST;
    else if (wr_en && (paddr == `BOR_ADDR_OFFD))
      cfg_r.offd <= clamp_time(pwdata);
  end

  // status view
  always_comb
  begin
    stat.st_on = (st_r != BOR_ST_OFF);
    stat.latched = latch_r;
    stat.req = req;
    stat.holding = !hold_done;
    stat.offdly = (st_r == BOR_ST_OFFDLY);
    stat.relay = relay_r;
  end

  always_comb
  begin
    rd_word = 32'h00000000;
    unique case (paddr)
      `BOR_ADDR_CTRL:
      begin
        rd_word[`BOR_CTRL_INV_MSB:`BOR_CTRL_INV_LSB] = cfg_r.in_inv;
        rd_word[`BOR_CTRL_OUTINV] = cfg_r.out_inv;
        rd_word[`BOR_CTRL_LATCH] = cfg_r.latch_en;
      end
      `BOR_ADDR_HOLD:
        rd_word[14:0] = cfg_r.hold;
      `BOR_ADDR_OFFD:
        rd_word[14:0] = cfg_r.offd;
      `BOR_ADDR_STAT:
      begin
        rd_word[`BOR_STAT_ON] = stat.st_on;
        rd_word[`BOR_STAT_LATCHED] = stat.latched;
        rd_word[`BOR_STAT_REQ] = stat.req;
        rd_word[`BOR_STAT_HOLDING] = stat.holding;
        rd_word[`BOR_STAT_OFFDLY] = stat.offdly;
        rd_word[`BOR_STAT_RELAY] = stat.relay;
        rd_word[`BOR_STAT_SIG_MSB:`BOR_STAT_SIG_LSB] = sig_in;
      end
      `BOR_ADDR_HOLD_LEFT:
        rd_word[14:0] = hold_left;
      `BOR_ADDR_OFFD_LEFT:
        rd_word[14:0] = offd_left;
      default:
        rd_word = 32'h00000000;
    endcase
  end

  // latch: a live request sets it and wins over a simultaneous acknowledge
  always_comb
  begin
    latch_nxt = latch_r;
    if (!cfg_r.latch_en)
      latch_nxt = 1'b0;
    else if (req)
      latch_nxt = 1'b1;
    else if (ack_in)
      latch_nxt = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      latch_r <= 1'b0;
    else
      latch_r <= latch_nxt;
  end

  assign demand = req || latch_r;

  // relay state sequence
  always_comb
  begin
    st_nxt = st_r;
    hold_start = 1'b0;
    off_start = 1'b0;
    unique case (st_r)
      BOR_ST_OFF:
      begin
        if (demand && hold_done)
        begin
          st_nxt = BOR_ST_ON;
          hold_start = 1'b1;
        end
      end
      BOR_ST_ON:
      begin
        if (!demand)
        begin
          st_nxt = BOR_ST_OFFDLY;
          off_start = 1'b1;
        end
      end
      BOR_ST_OFFDLY:
      begin
        // a returning request cancels the off delay and goes back to on without a new hold
        if (demand)
          st_nxt = BOR_ST_ON;
        else if (off_done && hold_done)
        begin
          st_nxt = BOR_ST_OFF;
          hold_start = 1'b1;
        end
      end
      default:
        st_nxt = BOR_ST_OFF;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_r <= BOR_ST_OFF;
    else
      st_r <= st_nxt;
  end

  // relay drive with output inversion
  assign relay_nxt = (st_r != BOR_ST_OFF) ^ cfg_r.out_inv;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      relay_r <= 1'b0;
    else
      relay_r <= relay_nxt;
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign relay_out = relay_r;

endmodule
`default_nettype wire

/* testbench/bor_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module bor_monitor
#(
  parameter int TICK_CYCLES = 4
)
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire bor_pkg::bor_addr_t paddr,
  input wire bor_pkg::bor_word_t pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // relay
  input wire bor_pkg::bor_sig_t sig_in,
  input wire logic ack_in,
  input wire logic relay_out
);
  import bor_pkg::*;
  logic [9:0] ctl_r;
  logic hld_r;
  logic off_r;
  wire logic rq = |(sig_in ^ ctl_r[6:0]);
  wire logic on = relay_out ^ ctl_r[8];
  // shadow of the settings that decide the relay timing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl_r <= '0;
      hld_r <= 1'b0;
      off_r <= 1'b0;
    end
    else if (psel && penable && pready && pwrite)
    begin
      if (paddr == 8'h00)
        ctl_r <= pwdata[9:0];
      if (paddr == 8'h04)
        hld_r <= |pwdata[14:0];
      if (paddr == 8'h08)
        off_r <= |pwdata[14:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_up;
    !hld_r && $rose(rq) ##1 rq [*2];
  endsequence
  sequence s_down;
    !hld_r && !off_r && !ctl_r[9] && $fell(rq) ##1 !rq [*3];
  endsequence
  sequence s_ack;
    !rq ##1 !rq && ack_in && ctl_r[9] && !hld_r && !off_r;
  endsequence
  a_ready_setup: assert property (psel && !penable |=> pready) else $error("no ready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
  a_bad_addr: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14}))
    else $error("bad error flag");
  a_pickup_time: assert property (s_up |=> on) else $error("late pickup");
  a_drop_time: assert property (s_down |=> !on) else $error("late dropout");
  a_hold_keep: assert property (hld_r && $changed(on) |=> $stable(on) [*3]) else $error("hold cut");
  a_latch_keep: assert property ((ctl_r[9] && !ack_in) [*6] ##0 on |=> on) else $error("latch lost");
  a_ack_release: assert property (s_ack |-> ##[1:8] !on) else $error("ack ignored");
endmodule
bind bor_top bor_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .sig_in, .ack_in, .relay_out);
`default_nettype wire

/* testbench/bor_load.sv */
`timescale 1ns/1ps
`default_nettype none
module bor_load
(
  // coil drive
  input wire logic pclk,
  input wire logic presetn,
  input wire logic relay_out,
  // contact
  output logic closed,
  output int ops
);
  // normally open contact follows the coil one cycle late
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      closed <= 1'b0;
      ops <= 0;
    end
    else
    begin
      closed <= relay_out;
      ops <= ops + int'(relay_out && !closed);
    end
  end
endmodule
`default_nettype wire

/* testbench/bor_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module bor_top_tb;
  import bor_pkg::*;
  localparam int TK = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  bor_addr_t paddr = '0;
  bor_word_t pwdata = '0;
  bor_word_t prdata;
  logic pready;
  logic pslverr;
  bor_sig_t sig_in = '0;
  logic ack_in = 1'b0;
  logic relay_out;
  logic closed;
  int ops;
  int num_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  bor_word_t rd;
  logic er;
  bor_top #(.TICK_CYCLES(TK)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sig_in, .ack_in, .relay_out);
  bor_load u_load (.pclk, .presetn, .relay_out, .closed, .ops);
  initial
  begin
    forever #50 pclk = ~pclk;
  end
  task automatic results();
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input bor_word_t e, input bor_word_t g);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected at %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic see(input logic e);
    wt(8);
    chk({31'h0, e}, {31'h0, closed});
  endtask
  task automatic apb(input logic w, input bor_addr_t a, input bor_word_t d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic t_regs();
    for (int a = 0; a < 24; a += 4)
    begin
      apb(1'b0, 8'(a), '0);
      chk('0, rd);
    end
    apb(1'b1, 8'h04, 32'h7531);
    apb(1'b0, 8'h04, '0);
    chk(32'h7530, rd);
    apb(1'b1, 8'h04, '0);
    apb(1'b0, 8'h20, '0);
    chk({31'h0, 1'b1}, {31'h0, er});
    chk('0, rd);
  endtask
  task automatic t_logic();
    for (int i = 0; i < 7; i++)
    begin
      sig_in <= 7'h01 << i;
      see(1'b1);
      apb(1'b1, 8'h00, 32'h1 << i);
      see(1'b0);
      sig_in <= 7'h00;
      see(1'b1);
      apb(1'b1, 8'h00, '0);
      see(1'b0);
    end
    apb(1'b1, 8'h00, 32'h100);
    see(1'b1);
    sig_in <= 7'h40;
    see(1'b0);
    sig_in <= 7'h00;
    apb(1'b1, 8'h00, '0);
    see(1'b0);
  endtask
  task automatic t_time();
    apb(1'b1, 8'h04, 32'h3);
    sig_in <= 7'h01;
    wt(2);
    sig_in <= 7'h00;
    wt(3 * TK + 3);
    chk(32'h1, {31'h0, closed});
    wt(1);
    chk(32'h0, {31'h0, closed});
    // the off state starts a hold of its own
    wt(3 * TK);
    apb(1'b1, 8'h04, '0);
    apb(1'b1, 8'h08, 32'h3);
    sig_in <= 7'h01;
    wt(4);
    sig_in <= 7'h00;
    wt(3 * TK + 5);
    chk(32'h1, {31'h0, closed});
    wt(1);
    chk(32'h0, {31'h0, closed});
    apb(1'b1, 8'h08, '0);
  endtask
  task automatic t_latch();
    int n0;
    n0 = ops;
    apb(1'b1, 8'h00, 32'h200);
    sig_in <= 7'h01;
    see(1'b1);
    sig_in <= 7'h00;
    see(1'b1);
    sig_in <= 7'h01;
    ack_in <= 1'b1;
    see(1'b1);
    sig_in <= 7'h00;
    see(1'b0);
    ack_in <= 1'b0;
    apb(1'b1, 8'h00, '0);
    ack_in <= 1'b1;
    sig_in <= 7'h01;
    see(1'b1);
    sig_in <= 7'h00;
    ack_in <= 1'b0;
    see(1'b0);
    chk(32'(n0 + 2), 32'(ops));
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      results();
    end
  end
  initial
  begin
    wt(16);
    presetn <= 1'b1;
    wt(1);
    t_regs();
    t_logic();
    t_time();
    t_latch();
    results();
  end
endmodule
`default_nettype wire
